// file: design/bitop_pkg.sv
// Shared constants and types for the bit, flag and transfer execution core.
// Assumes an 8-bit core with 32 working registers and pointer pairs in the top six.
package bitop_pkg;

  // Positions in the status flags word
  localparam logic [2:0] FLAG_C = 3'h0;
  localparam logic [2:0] FLAG_Z = 3'h1;
  localparam logic [2:0] FLAG_N = 3'h2;
  localparam logic [2:0] FLAG_V = 3'h3;
  localparam logic [2:0] FLAG_S = 3'h4;
  localparam logic [2:0] FLAG_H = 3'h5;
  localparam logic [2:0] FLAG_T = 3'h6;
  localparam logic [2:0] FLAG_I = 3'h7;

  // Reset values
  localparam logic [7:0]  STATUS_RESET = 8'h00;
  localparam logic [7:0]  REG_RESET    = 8'h00;
  localparam logic [15:0] SP_RESET     = 16'h00FF;

  // Low register index of each pointer pair
  localparam logic [4:0] PTR_X_LO = 5'h1A;
  localparam logic [4:0] PTR_Y_LO = 5'h1C;
  localparam logic [4:0] PTR_Z_LO = 5'h1E;

  // Decoded operations accepted by the core
  typedef enum logic [3:0] {
    OP_NOP,
    OP_BIT_INTO_TRANSFER_FLAG,
    OP_TRANSFER_FLAG_INTO_BIT,
    OP_FLAG_RAISE,
    OP_FLAG_LOWER,
    OP_ARITHMETIC_RIGHT_SHIFT,
    OP_SWAP_NIBBLES,
    OP_READ_INDIRECT,
    OP_WRITE_INDIRECT,
    OP_READ_DIRECT,
    OP_WRITE_DIRECT,
    OP_PROGRAM_MEMORY_READ,
    OP_PUSH,
    OP_POP
  } op_e;

  // Pointer pair selection
  typedef enum logic [1:0] {PTR_X, PTR_Y, PTR_Z} ptr_e;

  // Addressing form for indirect and program reads
  typedef enum logic [1:0] {PM_PLAIN, PM_POST_INC, PM_PRE_DEC, PM_DISPLACED} ptr_mode_e;

endpackage

// file: design/alu_if.sv
// Carrier between the core and its single-cycle bit and flag unit.
// Assumes both ends sit in the same clock domain; all signals combinational.
`timescale 1ns/10ps
interface alu_if;
  import bitop_pkg::*;
  op_e        op;
  logic [7:0] operand;
  logic [2:0] bit_sel;
  logic [7:0] flags_in;
  logic [7:0] result;
  logic [7:0] flags_out;

  modport core (output op, operand, bit_sel, flags_in, input result, flags_out);
  modport unit (input op, operand, bit_sel, flags_in, output result, flags_out);
endinterface

// file: design/bit_flag_unit.sv
// Combinational unit for bit moves, flag forcing, arithmetic shift and nibble swap.
// Assumes the caller registers its results and only applies them on accepted ops.
`timescale 1ns/10ps
module bit_flag_unit (
  alu_if.unit alu
);
  import bitop_pkg::*;

  // Result and new flags; untouched fields pass through
  always_comb begin
    alu.result    = alu.operand;
    alu.flags_out = alu.flags_in;
    unique case (alu.op)
      OP_BIT_INTO_TRANSFER_FLAG: alu.flags_out[FLAG_T] = alu.operand[alu.bit_sel];
      OP_TRANSFER_FLAG_INTO_BIT: alu.result[alu.bit_sel] = alu.flags_in[FLAG_T];
      OP_FLAG_RAISE:             alu.flags_out[alu.bit_sel] = 1'b1;
      OP_FLAG_LOWER:             alu.flags_out[alu.bit_sel] = 1'b0;
      OP_ARITHMETIC_RIGHT_SHIFT: begin
        alu.result            = {alu.operand[7], alu.operand[7:1]};
        alu.flags_out[FLAG_C] = alu.operand[0];
        alu.flags_out[FLAG_N] = alu.operand[7];
        alu.flags_out[FLAG_V] = alu.operand[7] ^ alu.operand[0];
        alu.flags_out[FLAG_Z] = ({alu.operand[7], alu.operand[7:1]} == 8'h00);
      end
      OP_SWAP_NIBBLES:           alu.result = {alu.operand[3:0], alu.operand[7:4]};
      default: begin
      end
    endcase
  end
endmodule

// file: design/bitop_core.sv
// Execution core for bit, status-flag and data-transfer operations.
// Assumes decoded operations arrive synchronous to sys_clk with a valid/ready handshake,
// data memory answers reads in the same cycle, program memory one cycle after its strobe.
`timescale 1ns/10ps
module bitop_core #(
  parameter logic [15:0] SP_INIT = bitop_pkg::SP_RESET
) (
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire logic                  instr_valid,
  output logic                       instr_ready,
  input  wire bitop_pkg::op_e        instr_op,
  input  wire logic [4:0]            instr_rd,
  input  wire logic [4:0]            instr_rr,
  input  wire logic [2:0]            instr_bit,
  input  wire bitop_pkg::ptr_e       instr_ptr,
  input  wire bitop_pkg::ptr_mode_e  instr_mode,
  input  wire logic [5:0]            instr_disp,
  input  wire logic [15:0]           instr_addr,
  output logic                       instr_illegal,
  output logic [15:0]                dmem_addr,
  output logic [7:0]                 dmem_wdata,
  output logic                       dmem_we,
  output logic                       dmem_re,
  input  wire logic [7:0]            dmem_rdata,
  output logic [15:0]                pmem_addr,
  output logic                       pmem_re,
  input  wire logic [7:0]            pmem_rdata,
  input  wire logic [4:0]            peek_sel,
  output logic [7:0]                 peek_data,
  output logic [7:0]                 status_flags_word,
  output logic [15:0]                stack_ptr
);
  import bitop_pkg::*;

  typedef enum logic [1:0] {S_IDLE, S_MEM, S_PROG1, S_PROG2} state_e;

  state_e      state_q;
  logic [7:0]  rf_q [32];
  logic [7:0]  status_q;
  logic [15:0] sp_q;
  logic [4:0]  rd_q;
  logic [2:0]  bit_q;
  ptr_e        ptr_q;
  logic        post_inc_q;
  logic [15:0] dmem_addr_q;
  logic [7:0]  dmem_wdata_q;
  logic        dmem_we_q;
  logic        dmem_re_q;
  logic [15:0] pmem_addr_q;
  logic        pmem_re_q;
  logic [7:0]  peek_q;
  logic        illegal_q;

  logic        accept;
  logic        bad;
  logic        take;
  logic        is_ind;
  logic        is_load;
  logic        is_store;
  logic [15:0] ptr_now;
  logic [15:0] ptr_cur;
  logic [15:0] ea;
  logic [4:0]  lo_now;
  logic [4:0]  lo_cur;

  alu_if alu ();

  // Low register index of a pointer pair
  function automatic logic [4:0] ptr_lo(input ptr_e sel);
    unique case (sel)
      PTR_X:   return PTR_X_LO;
      PTR_Y:   return PTR_Y_LO;
      default: return PTR_Z_LO;
    endcase
  endfunction

  // Single-bit mask for a flag position
  function automatic logic [7:0] flag_mask(input logic [2:0] pos);
    return 8'h01 << pos;
  endfunction

  bit_flag_unit u_unit (
    .alu (alu)
  );

  // Operand routing into the bit and flag unit
  assign alu.op       = instr_op;
  assign alu.operand  = (instr_op == OP_BIT_INTO_TRANSFER_FLAG) ? rf_q[instr_rr] : rf_q[instr_rd];
  assign alu.bit_sel  = instr_bit;
  assign alu.flags_in = status_q;

  // Handshake and operation classes
  assign instr_ready = (state_q == S_IDLE);
  assign accept      = instr_valid && instr_ready;
  assign is_ind      = (instr_op == OP_READ_INDIRECT) || (instr_op == OP_WRITE_INDIRECT);
  assign is_load     = (instr_op == OP_READ_INDIRECT) || (instr_op == OP_READ_DIRECT) ||
                       (instr_op == OP_POP);
  assign is_store    = (instr_op == OP_WRITE_INDIRECT) || (instr_op == OP_WRITE_DIRECT) ||
                       (instr_op == OP_PUSH);
  // Displacement exists for Y and Z only; X with it is refused
  assign bad         = is_ind && (instr_mode == PM_DISPLACED) &&
                       (instr_ptr == PTR_X);
  assign take        = accept && !bad;
  assign lo_now      = ptr_lo(instr_ptr);
  assign lo_cur      = ptr_lo(ptr_q);
  assign ptr_now     = {rf_q[{lo_now[4:1], 1'b1}], rf_q[lo_now]};
  assign ptr_cur     = {rf_q[{lo_cur[4:1], 1'b1}], rf_q[lo_cur]};

  // Effective data address of the accepted operation
  always_comb begin
    ea = ptr_now;
    unique case (instr_op)
      OP_READ_INDIRECT, OP_WRITE_INDIRECT: begin
        if (instr_mode == PM_PRE_DEC) begin
          ea = ptr_now - 16'h0001;
        end else if (instr_mode == PM_DISPLACED) begin
          ea = ptr_now + {10'h000, instr_disp};
        end
      end
      OP_READ_DIRECT, OP_WRITE_DIRECT: ea = instr_addr;
      OP_PUSH:                         ea = sp_q;
      OP_POP:                          ea = sp_q + 16'h0001;
      default: begin
      end
    endcase
  end

  // Sequencer: one cycle in idle, memory ops add one, program reads add two
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= S_IDLE;
    end else begin
      unique case (state_q)
        S_IDLE: begin
          if (take && (is_load || is_store)) begin
            state_q <= S_MEM;
          end else if (take && (instr_op == OP_PROGRAM_MEMORY_READ)) begin
            state_q <= S_PROG1;
          end
        end
        S_MEM:   state_q <= S_IDLE;
        S_PROG1: state_q <= S_PROG2;
        S_PROG2: state_q <= S_IDLE;
      endcase
    end
  end

  // Operation context held over the later cycles
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_q       <= 5'h00;
      bit_q      <= 3'h0;
      ptr_q      <= PTR_X;
      post_inc_q <= 1'b0;
    end else if (accept) begin
      rd_q       <= instr_rd;
      bit_q      <= instr_bit;
      ptr_q      <= (instr_op == OP_PROGRAM_MEMORY_READ) ? PTR_Z : instr_ptr;
      post_inc_q <= take && (instr_mode == PM_POST_INC) &&
                    (is_ind || (instr_op == OP_PROGRAM_MEMORY_READ));
    end
  end

  // Data and program memory strobes, registered for one cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      dmem_addr_q  <= 16'h0000;
      dmem_wdata_q <= 8'h00;
      dmem_we_q    <= 1'b0;
      dmem_re_q    <= 1'b0;
      pmem_addr_q  <= 16'h0000;
      pmem_re_q    <= 1'b0;
    end else begin
      dmem_we_q <= take && is_store;
      dmem_re_q <= take && is_load;
      pmem_re_q <= take && (instr_op == OP_PROGRAM_MEMORY_READ);
      if (take) begin
        dmem_addr_q  <= ea;
        dmem_wdata_q <= rf_q[instr_rr];
        pmem_addr_q  <= {rf_q[{PTR_Z_LO[4:1], 1'b1}], rf_q[PTR_Z_LO]};
      end
    end
  end

  // Working registers; a load into a pointer byte wins over its update
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 32; i++) begin
        rf_q[i] <= REG_RESET;
      end
    end else begin
      if (take) begin
        if ((instr_op == OP_TRANSFER_FLAG_INTO_BIT) || (instr_op == OP_SWAP_NIBBLES) ||
            (instr_op == OP_ARITHMETIC_RIGHT_SHIFT)) begin
          rf_q[instr_rd] <= alu.result;
        end
        if (is_ind && (instr_mode == PM_PRE_DEC)) begin
          {rf_q[{lo_now[4:1], 1'b1}], rf_q[lo_now]} <= ptr_now - 16'h0001;
        end
      end
      if (((state_q == S_MEM) || (state_q == S_PROG2)) && post_inc_q) begin
        {rf_q[{lo_cur[4:1], 1'b1}], rf_q[lo_cur]} <= ptr_cur + 16'h0001;
      end
      if ((state_q == S_MEM) && dmem_re_q) begin
        rf_q[rd_q] <= dmem_rdata;
      end
      if (state_q == S_PROG2) begin
        rf_q[rd_q] <= pmem_rdata;
      end
    end
  end

  // Status flags word; only flag-affecting operations load it
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      status_q <= STATUS_RESET;
    end else if (take && ((instr_op == OP_BIT_INTO_TRANSFER_FLAG) ||
                          (instr_op == OP_FLAG_RAISE) || (instr_op == OP_FLAG_LOWER) ||
                          (instr_op == OP_ARITHMETIC_RIGHT_SHIFT))) begin
      status_q <= alu.flags_out;
    end
  end

  // Stack pointer moves when push or pop is taken
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sp_q <= SP_INIT;
    end else if (take && (instr_op == OP_PUSH)) begin
      sp_q <= sp_q - 16'h0001;
    end else if (take && (instr_op == OP_POP)) begin
      sp_q <= sp_q + 16'h0001;
    end
  end

  // Observation port and refusal pulse
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      peek_q    <= 8'h00;
      illegal_q <= 1'b0;
    end else begin
      peek_q    <= rf_q[peek_sel];
      illegal_q <= accept && bad;
    end
  end

  assign dmem_addr         = dmem_addr_q;
  assign dmem_wdata        = dmem_wdata_q;
  assign dmem_we           = dmem_we_q;
  assign dmem_re           = dmem_re_q;
  assign pmem_addr         = pmem_addr_q;
  assign pmem_re           = pmem_re_q;
  assign peek_data         = peek_q;
  assign instr_illegal     = illegal_q;
  assign status_flags_word = status_q;
  assign stack_ptr         = sp_q;

  // Helper values seen by the checks below
  logic       src_bit;
  logic [7:0] src_val;
  logic [7:0] asr_exp;
  logic [7:0] swap_exp;
  logic       op_lsb;
  assign src_bit  = alu.operand[instr_bit];
  assign src_val  = rf_q[instr_rr];
  assign asr_exp  = {alu.operand[7], alu.operand[7:1]};
  assign swap_exp = {alu.operand[3:0], alu.operand[7:4]};
  assign op_lsb   = alu.operand[0];

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_mem_beat;
    !instr_ready ##1 instr_ready;
  endsequence

  sequence s_prog_wait;
    (pmem_re && !instr_ready) ##1 (!pmem_re && !instr_ready) ##1 instr_ready;
  endsequence

  property p_flag_force(logic [2:0] f);
    take && ((instr_op == OP_FLAG_RAISE) || (instr_op == OP_FLAG_LOWER)) && (instr_bit == f)
      |=> (status_q[f] == ($past(instr_op) == OP_FLAG_RAISE)) && instr_ready &&
          (((status_q ^ $past(status_q)) & ~flag_mask(f)) == 8'h00);
  endproperty

  a_bit_into_t: assert property (
    take && (instr_op == OP_BIT_INTO_TRANSFER_FLAG) |=> (status_q[FLAG_T] == $past(src_bit)) &&
      (((status_q ^ $past(status_q)) & ~flag_mask(FLAG_T)) == 8'h00))
    else $error("transfer flag copy wrong");
  a_t_into_bit: assert property (
    take && (instr_op == OP_TRANSFER_FLAG_INTO_BIT) |=>
      (rf_q[rd_q][bit_q] == status_q[FLAG_T]) && $stable(status_q) && instr_ready)
    else $error("bit load from transfer flag wrong");
  a_overflow_force: assert property (p_flag_force(FLAG_V))
    else $error("overflow force wrong");
  a_half_force: assert property (p_flag_force(FLAG_H))
    else $error("half carry force wrong");
  a_sign_force: assert property (p_flag_force(FLAG_S))
    else $error("signed test force wrong");
  a_read_post_inc: assert property (
    take && (instr_op == OP_READ_INDIRECT) && (instr_mode == PM_POST_INC) |=>
      dmem_re && (dmem_addr == $past(ptr_now)) ##1 (ptr_cur == dmem_addr + 16'h0001))
    else $error("post-increment read wrong");
  a_read_pre_dec: assert property (
    take && (instr_op == OP_READ_INDIRECT) && (instr_mode == PM_PRE_DEC) |=>
      dmem_re && (dmem_addr == $past(ptr_now) - 16'h0001) && (ptr_cur == dmem_addr))
    else $error("pre-decrement read wrong");
  a_read_displaced: assert property (
    take && is_ind && (instr_mode == PM_DISPLACED) |=>
      (dmem_addr == $past(ptr_now) + {10'h000, $past(instr_disp)}) &&
      (ptr_cur == $past(ptr_now)) and s_mem_beat)
    else $error("displaced access wrong");
  a_write_direct: assert property (
    take && (instr_op == OP_WRITE_DIRECT) |=> dmem_we && (dmem_addr == $past(instr_addr)) &&
      (dmem_wdata == $past(src_val)) and s_mem_beat)
    else $error("direct write wrong");
  a_prog_three: assert property (
    take && (instr_op == OP_PROGRAM_MEMORY_READ) |=> s_prog_wait)
    else $error("program read timing wrong");
  a_push_stack: assert property (
    take && (instr_op == OP_PUSH) |=> dmem_we && (dmem_addr == $past(sp_q)) &&
      (sp_q == dmem_addr - 16'h0001) && $stable(status_q) and s_mem_beat)
    else $error("push wrong");
  a_pop_stack: assert property (
    take && (instr_op == OP_POP) |=> dmem_re && (dmem_addr == sp_q) &&
      (sp_q == $past(sp_q) + 16'h0001) and s_mem_beat)
    else $error("pop wrong");
  a_asr_shift: assert property (
    take && (instr_op == OP_ARITHMETIC_RIGHT_SHIFT) |=>
      (rf_q[rd_q] == $past(asr_exp)) && (status_q[FLAG_C] == $past(op_lsb)) && instr_ready)
    else $error("arithmetic shift wrong");
  a_swap_nibbles: assert property (
    take && (instr_op == OP_SWAP_NIBBLES) |=> (rf_q[rd_q] == $past(swap_exp)) && $stable(status_q))
    else $error("nibble swap wrong");
endmodule

// file: bench/tb.sv
// Self-checking bench for the bit, flag and transfer execution core.
// Assumes the valid/ready handshake, memory timing and reset behaviour of the core.
`timescale 1ns/10ps
module tb;
  import bitop_pkg::*;
  localparam logic [15:0] SP0 = 16'h0080;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        instr_valid = 1'b0;
  op_e         instr_op = OP_NOP;
  logic [4:0]  instr_rd = 5'h00;
  logic [4:0]  instr_rr = 5'h00;
  logic [2:0]  instr_bit = 3'h0;
  ptr_e        instr_ptr = PTR_X;
  ptr_mode_e   instr_mode = PM_PLAIN;
  logic [5:0]  instr_disp = 6'h00;
  logic [15:0] instr_addr = 16'h0000;
  logic [7:0]  pmem_rdata = 8'h00;
  logic [4:0]  peek_sel = 5'h00;
  logic        instr_ready, instr_illegal, dmem_we, dmem_re, pmem_re;
  logic [15:0] dmem_addr, pmem_addr, stack_ptr;
  logic [7:0]  dmem_wdata, dmem_rdata, peek_data, status_flags_word;
  logic [7:0]  mem [256];
  logic [3:0]  c1;
  logic [15:0] c1_addr, c1_paddr;
  logic [7:0]  c1_wdata;
  int          errors = 0;
  int          n_checks = 0;
  int          cycles = 0;
  int          ncyc;

  // Clock at 40 MHz
  always #12.5 sys_clk = ~sys_clk;

  function automatic logic [7:0] pm(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3C;
  endfunction

  // Data memory answers combinationally; outside a read strobe it shows garbage
  assign dmem_rdata = dmem_re ? mem[dmem_addr[7:0]] : ~mem[dmem_addr[7:0]];

  // Memory writes and program memory answer one cycle after its strobe
  always @(posedge sys_clk) begin
    if (dmem_we === 1'b1) mem[dmem_addr[7:0]] <= dmem_wdata;
    if (pmem_re === 1'b1) begin
      pmem_rdata <= pm(pmem_addr);
    end else begin
      pmem_rdata <= ~pmem_rdata;
    end
  end

  bitop_core #(.SP_INIT(SP0)) dut_u (
    .sys_clk(sys_clk), .rst(rst), .instr_valid(instr_valid), .instr_ready(instr_ready),
    .instr_op(instr_op), .instr_rd(instr_rd), .instr_rr(instr_rr), .instr_bit(instr_bit),
    .instr_ptr(instr_ptr), .instr_mode(instr_mode), .instr_disp(instr_disp),
    .instr_addr(instr_addr), .instr_illegal(instr_illegal), .dmem_addr(dmem_addr),
    .dmem_wdata(dmem_wdata), .dmem_we(dmem_we), .dmem_re(dmem_re),
    .dmem_rdata(dmem_rdata), .pmem_addr(pmem_addr), .pmem_re(pmem_re),
    .pmem_rdata(pmem_rdata), .peek_sel(peek_sel), .peek_data(peek_data),
    .status_flags_word(status_flags_word), .stack_ptr(stack_ptr));

  // Cuts a hung run short
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      errors++;
      $display("CHECK FAILED at %0t: run did not finish", $time);
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Offers one operation, captures cycle-one strobes and counts cycles until ready
  task automatic run(input op_e op, input logic [4:0] rd, input logic [4:0] rr,
                     input logic [2:0] b, input ptr_e p, input ptr_mode_e m,
                     input logic [5:0] d, input logic [15:0] a);
    logic [7:0] st0;
    st0 = status_flags_word;
    instr_valid <= 1'b1;
    instr_op <= op;
    instr_rd <= rd;
    instr_rr <= rr;
    instr_bit <= b;
    instr_ptr <= p;
    instr_mode <= m;
    instr_disp <= d;
    instr_addr <= a;
    @(posedge sys_clk);
    instr_valid <= 1'b0;
    ncyc = 1;
    @(negedge sys_clk);
    c1 = {dmem_we, dmem_re, pmem_re, instr_illegal};
    c1_addr = dmem_addr;
    c1_paddr = pmem_addr;
    c1_wdata = dmem_wdata;
    while (instr_ready !== 1'b1 && ncyc < 10) begin
      @(negedge sys_clk);
      ncyc++;
    end
    if (!(op inside {OP_FLAG_RAISE, OP_FLAG_LOWER, OP_BIT_INTO_TRANSFER_FLAG,
                     OP_ARITHMETIC_RIGHT_SHIFT})) begin
      chk({8'h00, status_flags_word}, {8'h00, st0}, "flags kept");
    end
    @(posedge sys_clk);
  endtask

  task automatic op1(input op_e op, input logic [4:0] r, input logic [2:0] b);
    run(op, r, r, b, PTR_X, PM_PLAIN, 6'h00, 16'h0000);
  endtask

  task automatic pop1(input op_e op, input logic [4:0] r, input ptr_e p,
                      input ptr_mode_e m, input logic [5:0] d);
    run(op, r, r, 3'h0, p, m, d, 16'h0000);
  endtask

  // Register contents appear on the peek port one cycle after selection
  task automatic peek(input logic [4:0] r, input logic [7:0] exp, input string what);
    peek_sel <= r;
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk({8'h00, peek_data}, {8'h00, exp}, what);
    @(posedge sys_clk);
  endtask

  task automatic setreg(input logic [4:0] r, input logic [7:0] v);
    mem[8'hF0] = v;
    run(OP_READ_DIRECT, r, 5'h00, 3'h0, PTR_X, PM_PLAIN, 6'h00, 16'h00F0);
    chk({12'h000, c1}, 16'h0004, "direct read strobe");
    chk(c1_addr, 16'h00F0, "direct read address");
    chk(16'(ncyc), 16'h0002, "direct read cycles");
  endtask

  task automatic setptr(input logic [4:0] lo, input logic [15:0] v);
    setreg(lo, v[7:0]);
    setreg(lo + 5'h01, v[15:8]);
  endtask

  task automatic chkptr(input logic [4:0] lo, input logic [15:0] v);
    peek(lo, v[7:0], "pointer low");
    peek(lo + 5'h01, v[15:8], "pointer high");
  endtask

  task automatic t_flags();
    logic [7:0] e;
    e = 8'h00;
    for (int b = 0; b < 8; b++) begin
      op1(OP_FLAG_RAISE, 5'h00, 3'(b));
      e[b] = 1'b1;
      chk({8'h00, status_flags_word}, {8'h00, e}, "raise");
      chk(16'(ncyc), 16'h0001, "raise cycles");
    end
    for (int b = 0; b < 8; b++) begin
      op1(OP_FLAG_LOWER, 5'h00, 3'(b));
      e[b] = 1'b0;
      chk({8'h00, status_flags_word}, {8'h00, e}, "lower");
      chk(16'(ncyc), 16'h0001, "lower cycles");
    end
  endtask

  task automatic t_bits();
    op1(OP_FLAG_RAISE, 5'h00, 3'h3);
    setreg(5'h05, 8'h40);
    op1(OP_BIT_INTO_TRANSFER_FLAG, 5'h05, 3'h6);
    chk({8'h00, status_flags_word}, 16'h0048, "bit into flag set");
    chk(16'(ncyc), 16'h0001, "bit into flag cycles");
    op1(OP_BIT_INTO_TRANSFER_FLAG, 5'h05, 3'h0);
    chk({8'h00, status_flags_word}, 16'h0008, "bit into flag clear");
    op1(OP_BIT_INTO_TRANSFER_FLAG, 5'h05, 3'h6);
    setreg(5'h06, 8'h00);
    op1(OP_TRANSFER_FLAG_INTO_BIT, 5'h06, 3'h3);
    chk(16'(ncyc), 16'h0001, "flag into bit cycles");
    peek(5'h06, 8'h08, "flag into bit");
  endtask

  task automatic t_shift_swap();
    setreg(5'h07, 8'h81);
    op1(OP_ARITHMETIC_RIGHT_SHIFT, 5'h07, 3'h0);
    chk(16'(ncyc), 16'h0001, "shift cycles");
    chk({15'h0000, status_flags_word[0]}, 16'h0001, "shift carry");
    peek(5'h07, 8'hC0, "shift result");
    setreg(5'h08, 8'h3C);
    op1(OP_SWAP_NIBBLES, 5'h08, 3'h0);
    chk(16'(ncyc), 16'h0001, "swap cycles");
    peek(5'h08, 8'hC3, "swap result");
  endtask

  task automatic t_transfer();
    setptr(PTR_Y_LO, 16'h0040);
    pop1(OP_READ_INDIRECT, 5'h02, PTR_Y, PM_POST_INC, 6'h00);
    chk(c1_addr, 16'h0040, "post inc address");
    chk(16'(ncyc), 16'h0002, "post inc cycles");
    peek(5'h02, mem[8'h40], "post inc data");
    chkptr(PTR_Y_LO, 16'h0041);
    pop1(OP_READ_INDIRECT, 5'h03, PTR_Y, PM_PRE_DEC, 6'h00);
    chk(c1_addr, 16'h0040, "pre dec address");
    chk(16'(ncyc), 16'h0002, "pre dec cycles");
    peek(5'h03, mem[8'h40], "pre dec data");
    chkptr(PTR_Y_LO, 16'h0040);
    setptr(PTR_Z_LO, 16'h0050);
    pop1(OP_READ_INDIRECT, 5'h04, PTR_Z, PM_DISPLACED, 6'h25);
    chk(c1_addr, 16'h0075, "displaced address");
    chk(16'(ncyc), 16'h0002, "displaced cycles");
    peek(5'h04, mem[8'h75], "displaced data");
    chkptr(PTR_Z_LO, 16'h0050);
    setptr(PTR_X_LO, 16'h0060);
    pop1(OP_READ_INDIRECT, 5'h02, PTR_X, PM_DISPLACED, 6'h01);
    chk({12'h000, c1}, 16'h0001, "displaced via X refused");
    chkptr(PTR_X_LO, 16'h0060);
    pop1(OP_WRITE_INDIRECT, 5'h04, PTR_X, PM_POST_INC, 6'h00);
    chk({12'h000, c1}, 16'h0008, "post inc write strobe");
    chk({c1_addr[7:0], c1_wdata}, {8'h60, mem[8'h75]}, "post inc write");
    chk(16'(ncyc), 16'h0002, "post inc write cycles");
    chkptr(PTR_X_LO, 16'h0061);
    pop1(OP_WRITE_INDIRECT, 5'h03, PTR_X, PM_PRE_DEC, 6'h00);
    chk({c1_addr[7:0], c1_wdata}, {8'h60, mem[8'h40]}, "pre dec write");
    chk(16'(ncyc), 16'h0002, "pre dec write cycles");
    chkptr(PTR_X_LO, 16'h0060);
    pop1(OP_WRITE_INDIRECT, 5'h04, PTR_Y, PM_DISPLACED, 6'h3F);
    chk({8'h00, mem[8'h7F]}, {8'h00, mem[8'h75]}, "displaced write");
    chk(16'(ncyc), 16'h0002, "displaced write cycles");
    chkptr(PTR_Y_LO, 16'h0040);
    run(OP_WRITE_DIRECT, 5'h00, 5'h03, 3'h0, PTR_X, PM_PLAIN, 6'h00, 16'h0070);
    chk({c1_addr[7:0], c1_wdata}, {8'h70, mem[8'h40]}, "direct write");
    chk(16'(ncyc), 16'h0002, "direct write cycles");
  endtask

  task automatic t_program_and_stack();
    setptr(PTR_Z_LO, 16'h1234);
    pop1(OP_PROGRAM_MEMORY_READ, 5'h00, PTR_Z, PM_PLAIN, 6'h00);
    chk({c1_paddr[11:0], c1}, {12'h234, 4'h2}, "program read strobe");
    chk(16'(ncyc), 16'h0003, "program read cycles");
    peek(5'h00, pm(16'h1234), "program read data");
    pop1(OP_PROGRAM_MEMORY_READ, 5'h09, PTR_Z, PM_POST_INC, 6'h00);
    chk(16'(ncyc), 16'h0003, "program read inc cycles");
    peek(5'h09, pm(16'h1234), "program read inc data");
    chkptr(PTR_Z_LO, 16'h1235);
    op1(OP_PUSH, 5'h04, 3'h0);
    chk({c1_addr[7:0], c1_wdata}, {SP0[7:0], mem[8'h75]}, "push");
    chk(stack_ptr, SP0 - 16'h0001, "push pointer");
    chk(16'(ncyc), 16'h0002, "push cycles");
    op1(OP_PUSH, 5'h03, 3'h0);
    op1(OP_POP, 5'h0A, 3'h0);
    chk({c1_addr[11:0], c1}, {SP0[11:0] - 12'h001, 4'h4}, "pop strobe");
    chk(16'(ncyc), 16'h0002, "pop cycles");
    peek(5'h0A, mem[8'h40], "pop data");
    op1(OP_POP, 5'h0B, 3'h0);
    peek(5'h0B, mem[8'h75], "second pop data");
    chk(stack_ptr, SP0, "pop pointer");
  endtask

  // Main sequence: reset, then every scenario in turn
  initial begin
    foreach (mem[i]) mem[i] = 8'(i) ^ 8'h5A;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    chk({stack_ptr[7:0], status_flags_word}, {SP0[7:0], STATUS_RESET}, "reset state");
    t_flags();
    t_bits();
    t_shift_swap();
    t_transfer();
    t_program_and_stack();
    test_done();
  end
endmodule
